// File: dv/mdrap_station.sv
// Purpose: Behavioural management station that clocks frames into the port and reads answers back.
// Assumes: Each MDC level lasts four CLK cycles, far below the top serial rate.
// Notes: MDC stands low between frames; the data line is pulled up when released.
module mdrap_station (
   input  wire logic clk,
   input  wire logic mdio_w,
   output logic      mdc,
   output logic      st_o,
   output logic      st_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      mdc   = 1'b0;
      st_o  = 1'b1;
      st_oe = 1'b0;
   end

   // The wire is sampled just before the rise, while the current bit still stands.
   task automatic bit_cyc(input logic b, input logic drv, output logic smp);
      st_o  <= b;
      st_oe <= drv;
      mdc   <= 1'b0;
      repeat (4) @(posedge clk);
      smp = mdio_w;
      mdc <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // Only this station is active, so no other access path competes with it.
   task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic        s;
      logic [31:0] hdr;
      rd  = 16'h0000;
      hdr = {2'h0, op, port, dev, 2'h2, wd};
      for (int i = 0; i < pre; i++) begin
         bit_cyc(1'b1, 1'b1, s);
      end
      for (int i = 31; i >= 0; i--) begin
         bit_cyc(hdr[i], !(op[1] && i < 18), s);
         if (i < 16) begin
            rd = {rd[14:0], s};
         end
      end
      st_oe <= 1'b0;
      mdc   <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the management frame slave.
// Assumes: A behavioural station drives MDC and shares the pulled-up data line.
// Notes: Table rows write and read back one register each; odd cases follow.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        w32;
      logic [2:0]  pa;
      logic [1:0]  ch;
      logic [4:0]  dev;
      logic [15:0] off;
      logic [31:0] d;
   } mdrap_tbrow_t;

   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic [2:0]   paddr = 3'h0;
   logic         mdc;
   logic         mdio_o;
   logic         mdio_oe;
   logic         st_o;
   logic         st_oe;
   logic         mdio_w;
   logic [15:0]  r;
   logic [31:0]  r32;
   int           error_cnt = 0;
   int           total_checks = 0;
   mdrap_tbrow_t rows [8];

   assign mdio_w = mdio_oe ? mdio_o : (st_oe ? st_o : 1'b1);
   always #5 clk = ~clk;

   mdrap_port #(.RAW(4)) uut (.CLK(clk), .RST(rst), .MDC(mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o),
                              .MDIO_OE(mdio_oe), .PADDR(paddr));
   mdrap_station stn (.clk(clk), .mdio_w(mdio_w), .mdc(mdc), .st_o(st_o), .st_oe(st_oe));

   task automatic conclude;
      $display("checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic acc(input logic [1:0] op, input logic [1:0] ch, input logic [4:0] dev, input logic [15:0] d);
      stn.frame(32, op, {paddr, ch}, dev, d, r);
   endtask

   task automatic wr16(input logic [1:0] ch, input logic [4:0] dev, input logic [15:0] off, input logic [15:0] d);
      acc(mdrap_pkg::OP_ADDR, ch, dev, off);
      acc(mdrap_pkg::OP_WRITE, ch, dev, d);
   endtask

   task automatic rd16(input logic [1:0] ch, input logic [4:0] dev, input logic [15:0] off);
      acc(mdrap_pkg::OP_ADDR, ch, dev, off);
      acc(mdrap_pkg::OP_READ, ch, dev, 16'h0000);
   endtask

   // Upper half first, then lower; all four frames every time.
   task automatic wr32(input logic [1:0] ch, input logic [4:0] dev, input logic [15:0] off, input logic [31:0] d);
      wr16(ch, dev, off + 16'h0001, d[31:16]);
      wr16(ch, dev, off, d[15:0]);
   endtask

   // The full three-step read is repeated per register, never chained.
   task automatic rd32(input logic [1:0] ch, input logic [4:0] dev, input logic [15:0] off);
      acc(mdrap_pkg::OP_ADDR, ch, dev, off);
      acc(mdrap_pkg::OP_RDINC, ch, dev, 16'h0000);
      r32[15:0] = r;
      acc(mdrap_pkg::OP_READ, ch, dev, 16'h0000);
      r32[31:16] = r;
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      conclude();
   end

   initial begin
      rows[0] = '{1'b0, 3'h0, 2'h0, mdrap_pkg::MMD_LPMA, 16'h0001, 32'h0000_1234};
      rows[1] = '{1'b0, 3'h7, 2'h3, mdrap_pkg::MMD_RCMP, 16'h0002, 32'h0000_a5c3};
      rows[2] = '{1'b0, 3'h3, 2'h1, mdrap_pkg::MMD_LBKP, 16'h0003, 32'h0000_0f0f};
      rows[3] = '{1'b0, 3'h5, 2'h2, mdrap_pkg::MMD_HPMA, 16'h0004, 32'h0000_8001};
      rows[4] = '{1'b0, 3'h1, 2'h0, mdrap_pkg::MMD_HBKP, 16'h0005, 32'h0000_7e7e};
      rows[5] = '{1'b0, 3'h6, 2'h1, mdrap_pkg::MMD_GLOB, 16'h0006, 32'h0000_00ff};
      rows[6] = '{1'b1, 3'h2, 2'h2, mdrap_pkg::MMD_LPMA, 16'h0008, 32'hdead_beef};
      rows[7] = '{1'b1, 3'h4, 2'h3, mdrap_pkg::MMD_HPMA, 16'h000e, 32'h1357_9bdf};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("idle enable", 1'b0, mdio_oe);
      foreach (rows[i]) begin
         paddr <= rows[i].pa;
         @(posedge clk);
         if (rows[i].w32) begin
            wr32(rows[i].ch, rows[i].dev, rows[i].off, rows[i].d);
            rd32(rows[i].ch, rows[i].dev, rows[i].off);
            check("wide reg", rows[i].d, r32);
         end else begin
            wr16(rows[i].ch, rows[i].dev, rows[i].off, rows[i].d[15:0]);
            rd16(rows[i].ch, rows[i].dev, rows[i].off);
            check("narrow reg", rows[i].d[15:0], r);
         end
      end
      paddr <= 3'h2;
      @(posedge clk);
      rd16(2'h2, mdrap_pkg::MMD_LBKP, 16'h000a);
      check("unwritten reg", 16'h0000, r);
      stn.frame(32, mdrap_pkg::OP_ADDR, 5'h16, mdrap_pkg::MMD_LPMA, 16'h0008, r);
      stn.frame(32, mdrap_pkg::OP_WRITE, 5'h16, mdrap_pkg::MMD_LPMA, 16'h0000, r);
      stn.frame(32, mdrap_pkg::OP_READ, 5'h16, mdrap_pkg::MMD_LPMA, 16'h0000, r);
      check("foreign port read", 16'hffff, r);
      rd32(2'h2, mdrap_pkg::MMD_LPMA, 16'h0008);
      check("foreign port write", 32'hdead_beef, r32);
      acc(mdrap_pkg::OP_READ, 2'h2, 5'h02, 16'h0000);
      check("unknown group", 16'hffff, r);
      wr16(2'h2, mdrap_pkg::MMD_LPMA, 16'h0009, 16'h4444);
      rd32(2'h2, mdrap_pkg::MMD_LPMA, 16'h0008);
      check("staged upper", 32'hdead_beef, r32);
      wr16(2'h2, mdrap_pkg::MMD_LPMA, 16'h0008, 16'h5555);
      rd32(2'h2, mdrap_pkg::MMD_LPMA, 16'h0008);
      check("committed pair", 32'h4444_5555, r32);
      wr16(2'h0, mdrap_pkg::MMD_LBKP, 16'h0008, 16'h6666);
      wr16(2'h0, mdrap_pkg::MMD_LBKP, 16'h0009, 16'h7777);
      rd16(2'h0, mdrap_pkg::MMD_LBKP, 16'h0009);
      check("narrow upper range", 16'h7777, r);
      wr16(2'h0, mdrap_pkg::MMD_LBKP, 16'h0010, 16'h8888);
      rd16(2'h0, mdrap_pkg::MMD_LBKP, 16'h0000);
      check("unmapped write", 16'h0000, r);
      wr16(2'h1, mdrap_pkg::MMD_GLOB, 16'h0000, 16'h1111);
      wr16(2'h1, mdrap_pkg::MMD_GLOB, 16'h0001, 16'h2222);
      acc(mdrap_pkg::OP_ADDR, 2'h1, mdrap_pkg::MMD_GLOB, 16'h0000);
      acc(mdrap_pkg::OP_RDINC, 2'h1, mdrap_pkg::MMD_GLOB, 16'h0000);
      check("read-inc data", 16'h1111, r);
      acc(mdrap_pkg::OP_READ, 2'h1, mdrap_pkg::MMD_GLOB, 16'h0000);
      check("advanced addr", 16'h2222, r);
      stn.frame(31, mdrap_pkg::OP_READ, 5'h09, mdrap_pkg::MMD_GLOB, 16'h0000, r);
      check("short preamble", 16'hffff, r);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd32(2'h2, mdrap_pkg::MMD_LPMA, 16'h0008);
      check("cleared by reset", 32'h0000_0000, r32);
      conclude();
   end
endmodule

// File: include/mdrap_pkg.sv
// Purpose: Shared constants and types for the management data register access port.
// Assumes: One 100 MHz clock; MDC and MDIO are sampled as synchronous inputs.
// Notes: Frame layout is preamble, start, op, port, device, turnaround, 16 data bits.
// Contract
// - Register groups are decoded by device number 1, 4, 7, 9, F and 1E.
// - The port speaks the indirect-addressing frame protocol on one data line and a station-driven clock.
// - Address, write, read and read-increment are supported, and read-increment advances the address by one.
// - Each channel answers only to the strap bits as upper three bits and its channel number as lower two.
// - One device takes four consecutive port addresses, so eight strap settings share one bus.
// - A 32-bit read sets the lower-half address, read-increment returns bits 15:0, a plain read bits 31:16.
// - Each 32-bit register has two addresses, one for each 16-bit half.
// - The two-half scheme applies only to the 32-bit blocks, other registers stay 16 bits wide.
package mdrap_pkg;
   localparam int unsigned PRE_BITS = 32;
   localparam int unsigned HDR_BITS = 12;
   localparam int unsigned DAT_BITS = 16;
   localparam logic [1:0]  OP_ADDR  = 2'h0;
   localparam logic [1:0]  OP_WRITE = 2'h1;
   localparam logic [1:0]  OP_RDINC = 2'h2;
   localparam logic [1:0]  OP_READ  = 2'h3;
   localparam logic [4:0]  MMD_LPMA = 5'h01;
   localparam logic [4:0]  MMD_RCMP = 5'h04;
   localparam logic [4:0]  MMD_LBKP = 5'h07;
   localparam logic [4:0]  MMD_HPMA = 5'h09;
   localparam logic [4:0]  MMD_HBKP = 5'h0f;
   localparam logic [4:0]  MMD_GLOB = 5'h1e;
   localparam logic [2:0]  MMD_NONE = 3'h7;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [31:0] REG_RST  = 32'h0000_0000;
   typedef enum logic [4:0] {
      S_PRE = 5'h01,
      S_ST  = 5'h02,
      S_HDR = 5'h04,
      S_TA  = 5'h08,
      S_DAT = 5'h10
   } mdrap_state_t;
endpackage

// File: src/mdrap_port.sv
// Purpose: Management frame slave serving four channels of register space.
// Assumes: MDC runs far slower than CLK; each MDC level lasts at least three CLK cycles.
// Notes: Output changes just after the MDC rising edge on which the station samples.
module mdrap_port #(
   parameter int RAW = 4
) (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       MDC,
   input  wire logic       MDIO_I,
   output logic            MDIO_O,
   output logic            MDIO_OE,
   input  wire logic [2:0] PADDR
);
   localparam int AW = 5 + RAW;

   function automatic logic [2:0] mmd_idx(input logic [4:0] dev);
      case (dev)
         mdrap_pkg::MMD_LPMA: mmd_idx = 3'h0;
         mdrap_pkg::MMD_RCMP: mmd_idx = 3'h1;
         mdrap_pkg::MMD_LBKP: mmd_idx = 3'h2;
         mdrap_pkg::MMD_HPMA: mmd_idx = 3'h3;
         mdrap_pkg::MMD_HBKP: mmd_idx = 3'h4;
         mdrap_pkg::MMD_GLOB: mmd_idx = 3'h5;
         default:             mmd_idx = mdrap_pkg::MMD_NONE;
      endcase
   endfunction

   mdrap_pkg::mdrap_state_t state_reg, state_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [15:0] sh_reg, sh_next;
   logic [1:0]  op_reg, op_next;
   logic [4:0]  prt_reg, prt_next;
   logic [4:0]  dev_reg, dev_next;
   logic        mine_reg, mine_next;
   logic [15:0] stage_reg, stage_next;
   logic [15:0] out_reg, out_next;
   logic        o_reg, o_next;
   logic        oe_reg, oe_next;
   logic        mdc_reg;
   logic [15:0] addr_reg [32];
   logic [15:0] addr_next [32];

   logic          rise;
   logic [11:0]   hdr;
   logic [15:0]   word;
   logic [4:0]    idx;
   logic [15:0]   cur_addr;
   logic          mapped;
   logic          wide;
   logic          fin;
   logic          ta_load;
   logic [AW-1:0] mem_raddr;
   logic [31:0]   mem_rdata;
   logic          mem_we;
   logic [31:0]   mem_wdata;
   logic [15:0]   rd16;

   assign rise     = MDC && !mdc_reg;
   assign hdr      = {sh_reg[10:0], MDIO_I};
   assign word     = {sh_reg[14:0], MDIO_I};
   assign idx      = {prt_reg[1:0], mmd_idx(dev_reg)};
   assign cur_addr = addr_reg[idx];
   assign mapped   = (cur_addr[15:RAW] == '0);
   // Only the line and host PMA groups carry the 32-bit MAC and SerDes blocks, in their upper register range.
   assign wide     = ((dev_reg == mdrap_pkg::MMD_LPMA) || (dev_reg == mdrap_pkg::MMD_HPMA))
                     && cur_addr[RAW-1];
   // Both halves of a wide register share one storage word; bit 0 picks the half.
   assign mem_raddr = {idx, cur_addr[RAW-1:1], cur_addr[0] && !wide};
   assign fin      = rise && (state_reg == mdrap_pkg::S_DAT) && (cnt_reg == 6'(mdrap_pkg::DAT_BITS - 1));
   assign ta_load  = rise && (state_reg == mdrap_pkg::S_TA) && (cnt_reg == 6'h00) && mine_reg && op_reg[1];
   assign mem_we   = fin && mine_reg && (op_reg == mdrap_pkg::OP_WRITE) && mapped
                     && !(wide && cur_addr[0]);
   assign mem_wdata = wide ? {stage_reg, word} : {16'h0000, word};

   always_comb begin
      rd16 = 16'h0000;
      if (mapped) begin
         rd16 = (wide && cur_addr[0]) ? mem_rdata[31:16] : mem_rdata[15:0];
      end
   end

   mdrap_regmem #(
      .AW (AW)
   ) u_mem (
      .CLK   (CLK),
      .RST   (RST),
      .we    (mem_we),
      .waddr (mem_raddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      op_next    = op_reg;
      prt_next   = prt_reg;
      dev_next   = dev_reg;
      mine_next  = mine_reg;
      stage_next = stage_reg;
      out_next   = out_reg;
      o_next     = o_reg;
      oe_next    = oe_reg;
      addr_next  = addr_reg;
      if (rise) begin
         sh_next = word;
         case (state_reg)
            mdrap_pkg::S_PRE: begin
               if (MDIO_I) begin
                  if (cnt_reg < 6'(mdrap_pkg::PRE_BITS)) begin
                     cnt_next = cnt_reg + 6'h01;
                  end
               end else if (cnt_reg >= 6'(mdrap_pkg::PRE_BITS)) begin
                  state_next = mdrap_pkg::S_ST;
                  cnt_next   = 6'h00;
               end else begin
                  cnt_next = 6'h00;
               end
            end
            mdrap_pkg::S_ST: begin
               // The second start bit must be zero; a one restarts the preamble count.
               if (!MDIO_I) begin
                  state_next = mdrap_pkg::S_HDR;
                  cnt_next   = 6'h00;
               end else begin
                  state_next = mdrap_pkg::S_PRE;
                  cnt_next   = 6'h01;
               end
            end
            mdrap_pkg::S_HDR: begin
               if (cnt_reg == 6'(mdrap_pkg::HDR_BITS - 1)) begin
                  op_next    = hdr[11:10];
                  prt_next   = hdr[9:5];
                  dev_next   = hdr[4:0];
                  // Channel number is the low two port bits, so one device spans four addresses.
                  mine_next  = (hdr[9:7] == PADDR)
                               && (mmd_idx(hdr[4:0]) != mdrap_pkg::MMD_NONE);
                  state_next = mdrap_pkg::S_TA;
                  cnt_next   = 6'h00;
               end else begin
                  cnt_next = cnt_reg + 6'h01;
               end
            end
            mdrap_pkg::S_TA: begin
               if (cnt_reg == 6'h00) begin
                  cnt_next = 6'h01;
                  if (ta_load) begin
                     oe_next  = 1'b1;
                     o_next   = 1'b0;
                     out_next = rd16;
                  end
               end else begin
                  state_next = mdrap_pkg::S_DAT;
                  cnt_next   = 6'h00;
                  if (oe_reg) begin
                     o_next   = out_reg[15];
                     out_next = {out_reg[14:0], 1'b0};
                  end
               end
            end
            mdrap_pkg::S_DAT: begin
               if (cnt_reg == 6'(mdrap_pkg::DAT_BITS - 1)) begin
                  oe_next    = 1'b0;
                  o_next     = 1'b0;
                  state_next = mdrap_pkg::S_PRE;
                  cnt_next   = 6'h00;
                  if (mine_reg) begin
                     case (op_reg)
                        mdrap_pkg::OP_ADDR:  addr_next[idx] = word;
                        mdrap_pkg::OP_RDINC: addr_next[idx] = cur_addr + 16'h0001;
                        mdrap_pkg::OP_WRITE: begin
                           if (wide && cur_addr[0]) begin
                              stage_next = word;
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end else begin
                  cnt_next = cnt_reg + 6'h01;
                  if (oe_reg) begin
                     o_next   = out_reg[15];
                     out_next = {out_reg[14:0], 1'b0};
                  end
               end
            end
            default: begin
               state_next = mdrap_pkg::S_PRE;
               cnt_next   = 6'h00;
               oe_next    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= mdrap_pkg::S_PRE;
         cnt_reg   <= 6'h00;
         sh_reg    <= 16'h0000;
         op_reg    <= 2'h0;
         prt_reg   <= 5'h00;
         dev_reg   <= 5'h00;
         mine_reg  <= 1'b0;
         stage_reg <= 16'h0000;
         out_reg   <= 16'h0000;
         o_reg     <= 1'b0;
         oe_reg    <= 1'b0;
         mdc_reg   <= 1'b0;
         for (int i = 0; i < 32; i++) begin
            addr_reg[i] <= mdrap_pkg::ADDR_RST;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         op_reg    <= op_next;
         prt_reg   <= prt_next;
         dev_reg   <= dev_next;
         mine_reg  <= mine_next;
         stage_reg <= stage_next;
         out_reg   <= out_next;
         o_reg     <= o_next;
         oe_reg    <= oe_next;
         mdc_reg   <= MDC;
         addr_reg  <= addr_next;
      end
   end

   assign MDIO_O  = o_reg;
   assign MDIO_OE = oe_reg;

   // Counts MDC rising edges while driving; a read holds the line for exactly 17 bit times.
   logic [4:0] drv_cnt_reg;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         drv_cnt_reg <= 5'h00;
      end else if (!oe_reg) begin
         drv_cnt_reg <= 5'h00;
      end else if (rise) begin
         drv_cnt_reg <= drv_cnt_reg + 5'h01;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_ta_drive;
      $rose(MDIO_OE) ##0 !MDIO_O;
   endsequence

   // The staged half must hold the word that the upper-half write carried.
   sequence s_stage_take;
      ##1 (stage_reg == $past(word));
   endsequence

   AST_TA_ZERO: assert property (s_ta_drive or !$rose(MDIO_OE))
      else $error("Turnaround did not drive zero.");
   AST_DRIVE_LEN: assert property (MDIO_OE |-> drv_cnt_reg <= 5'h11)
      else $error("Data line driven too long.");
   AST_OWN_PORT: assert property ($rose(MDIO_OE) |-> (prt_reg[4:2] == PADDR) && op_reg[1])
      else $error("Answered a foreign port address.");
   AST_MMD_OK: assert property (mem_we |-> mmd_idx(dev_reg) != mdrap_pkg::MMD_NONE)
      else $error("Write to an undecoded device group.");
   AST_POSTINC: assert property (fin && mine_reg && (op_reg == mdrap_pkg::OP_RDINC)
      |=> cur_addr == $past(cur_addr) + 16'h0001)
      else $error("Read-increment did not advance the address.");
   AST_READ_KEEP: assert property (fin && (op_reg == mdrap_pkg::OP_READ) |=> $stable(cur_addr))
      else $error("Plain read changed the address.");
   AST_STAGE_ONLY: assert property (fin && mine_reg && wide && cur_addr[0] |-> !mem_we)
      else $error("Upper-half write reached storage.");
   AST_STAGE_LOAD: assert property (fin && mine_reg && (op_reg == mdrap_pkg::OP_WRITE)
      && wide && cur_addr[0] |-> s_stage_take)
      else $error("Upper-half write was not staged.");
   // Storage reads back two cycles after the commit, so this sees what really landed.
   AST_COMMIT: assert property (mem_we && wide
      |-> ##2 mem_rdata == {$past(stage_reg, 2), $past(word, 2)})
      else $error("Lower-half write lost the staged upper half.");
   AST_UPPER_HALF: assert property (ta_load && wide && cur_addr[0] && mapped
      |=> out_reg == $past(mem_rdata[31:16]))
      else $error("Upper-half read returned the wrong bits.");
   AST_NARROW: assert property (ta_load && !wide && mapped |=> out_reg == $past(mem_rdata[15:0]))
      else $error("16-bit register read returned the wrong bits.");
endmodule

// File: src/mdrap_regmem.sv
// Purpose: Register storage for all channels and device groups, 32 bits per word.
// Assumes: One write port and one registered read port on the same clock.
// Notes: Cleared at reset so that unwritten registers read as zero.
module mdrap_regmem #(
   parameter int AW = 9
) (
   input  wire logic          CLK,
   input  wire logic          RST,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [31:0]   rdata
);
   logic [31:0] mem_reg [2**AW];

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < 2**AW; i++) begin
            mem_reg[i] <= mdrap_pkg::REG_RST;
         end
         rdata <= mdrap_pkg::REG_RST;
      end else begin
         if (we) begin
            mem_reg[waddr] <= wdata;
         end
         rdata <= mem_reg[raddr];
      end
   end
endmodule
